// ===== fcsm_apb_host.sv
`timescale 1ns/10ps
// ****************
// Host bus master
// ****************
module fcsm_apb_host (
  // Clock
  input wire logic clk,
  // Bus toward the device
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // Idle bus from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end
  // One transfer; codes reach the device whole, one word each
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released address and data lines must not keep showing the old value; pwrite keeps it
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : fcsm_apb_host

// ===== fcsm_checker.sv
`timescale 1ns/10ps
`include "fcsm_params.svh"
// ****************
// Port checker
// ****************
module fcsm_checker (
  // Clock, reset, enable
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic CLK_EN,
  // APB
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Interrupt
  input wire logic IRQ
);
  logic wr;
  logic rd;
  logic bad;
  logic [31:0] link;
  logic [7:0] qty;
  // Taken write, read setup and unmapped word
  assign wr = PSEL && PENABLE && PWRITE && CLK_EN;
  assign rd = PSEL && !PENABLE && !PWRITE && CLK_EN;
  assign bad = PADDR[11:5] != 7'h00 || PADDR[1:0] != 2'h0;
  // Shadows, so reads can be judged without peeking inside
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      link <= `LINK_RESET;
      qty <= `QUANTITY_RESET;
    end else if (wr && PADDR == `OFS_LINK) begin
      link <= PWDATA;
    end else if (wr && PADDR == `OFS_QUANTITY) begin
      qty <= PWDATA[7:0];
    end
  end
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  a_ready_high:
    assert property (PREADY) else $error("PREADY low");
  a_err_map:
    assert property (PSEL && PENABLE |-> PSLVERR == bad) else $error("PSLVERR wrong");
  a_err_zero:
    assert property (rd && bad |=> PRDATA == 32'h0000_0000) else $error("unmapped read");
  a_rdata_hold:
    assert property (!rd |=> $stable(PRDATA)) else $error("PRDATA moved");
  a_link_value:
    assert property (rd && PADDR == `OFS_LINK |=> PRDATA == link) else $error("LINK read");
  a_qty_value:
    assert property (rd && PADDR == `OFS_QUANTITY |=> PRDATA == {26'h0, qty[5:0]})
    else $error("QUANTITY read");
  a_state_legal:
    assert property (rd && PADDR == `OFS_STATE |=> PRDATA[3:0] != 4'hF)
    else $error("bad state");
  a_rdstate_width:
    assert property (rd && PADDR == `OFS_READ_STATE |=> PRDATA[31:8] == 24'h00_0000)
    else $error("READ_STATE wide");
  a_irq_width:
    assert property (rd && PADDR == `OFS_IRQ_STATUS |=> PRDATA[31:3] == 29'h0000_0000)
    else $error("status wide");
  // Clearing every mask bit silences the registered interrupt two cycles after the write
  a_irq_masked:
    assert property (wr && PADDR == `OFS_IRQ_MASK && PWDATA[2:0] == 3'h0 |=> ##1 !IRQ)
    else $error("IRQ stayed high with all sources masked");
endmodule : fcsm_checker
bind flash_command_state_machine fcsm_checker fcsm_checker_inst (
  .SYS_CLK(SYS_CLK), .NRST(NRST), .CLK_EN(CLK_EN), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ));

// ===== fcsm_next_state.sv
`timescale 1ns/10ps
`include "fcsm_params.svh"
// Pure next-state table: depends on state and command only
module fcsm_next_state (
  // Current state and command
  input fcsm_pkg::cmd_state_type cur_state,
  input wire logic [7:0] cmd,
  // Result
  output fcsm_pkg::cmd_state_type next_state,
  output logic lock_error,
  output logic unlock_block,
  output logic bad_cmd
);
  import fcsm_pkg::*;

  // ****************************************
  // Next state table
  // ****************************************
  // Read state is not an input here, so it cannot steer a transition
  always_comb begin
    next_state = cur_state;
    lock_error = 1'b0;
    unlock_block = 1'b0;
    bad_cmd = 1'b0;
    case (cur_state)
      ST_READY: begin
        case (cmd)
          `CMD_PROGRAM_A, `CMD_PROGRAM_B: next_state = ST_PROG_SETUP;
          `CMD_BUFFERED: next_state = ST_BUF_SETUP;
          `CMD_ERASE: next_state = ST_ERASE_SETUP;
          `CMD_FACTORY: next_state = ST_FACT_SETUP;
          `CMD_LOCK_SETUP: next_state = ST_LOCK_SETUP;
          `CMD_OTP_SETUP: next_state = ST_OTP_SETUP;
          default: next_state = ST_READY;
        endcase
      end
      ST_LOCK_SETUP: begin
        next_state = ST_READY;
        unlock_block = (cmd == `CMD_CONFIRM);
        lock_error = (cmd != `CMD_CONFIRM);
      end
      ST_OTP_SETUP: next_state = ST_OTP_BUSY;
      ST_PROG_SETUP: next_state = ST_PROG_BUSY;
      ST_PROG_BUSY: begin
        if (cmd == `CMD_SUSPEND) begin
          next_state = ST_PROG_SUSP;
        end
      end
      ST_PROG_SUSP: begin
        if (cmd == `CMD_CONFIRM) begin
          next_state = ST_PROG_BUSY;
        end
      end
      ST_BUF_SETUP, ST_ERASE_SETUP, ST_FACT_SETUP: begin
        // Setups that need a confirm fall back to ready otherwise
        if (cmd == `CMD_CONFIRM) begin
          next_state = (cur_state == ST_BUF_SETUP) ? ST_BUF_BUSY :
                       (cur_state == ST_ERASE_SETUP) ? ST_ERASE_BUSY : ST_FACT_BUSY;
        end else begin
          next_state = ST_READY;
          bad_cmd = 1'b1;
        end
      end
      ST_BUF_BUSY: begin
        if (cmd == `CMD_SUSPEND) begin
          next_state = ST_BUF_SUSP;
        end
      end
      ST_BUF_SUSP: begin
        if (cmd == `CMD_CONFIRM) begin
          next_state = ST_BUF_BUSY;
        end
      end
      ST_ERASE_BUSY: begin
        if (cmd == `CMD_SUSPEND) begin
          next_state = ST_ERASE_SUSP;
        end
      end
      ST_ERASE_SUSP: begin
        if (cmd == `CMD_CONFIRM) begin
          next_state = ST_ERASE_BUSY;
        end
      end
      default: next_state = cur_state;
    endcase
  end
endmodule : fcsm_next_state

// ===== fcsm_params.svh
`ifndef FCSM_PARAMS_SVH
`define FCSM_PARAMS_SVH
// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define OFS_COMMAND 12'h000
`define OFS_STATE 12'h004
`define OFS_READ_STATE 12'h008
`define OFS_LINK 12'h00C
`define OFS_QUANTITY 12'h010
`define OFS_IRQ_STATUS 12'h014
`define OFS_IRQ_MASK 12'h018
`define OFS_DONE 12'h01C
// ****************************************
// Query addresses of the link field and quantity
// ****************************************
`define QUERY_EXT_BASE 12'h10A
`define QUERY_LINK_DELTA 12'h048
`define QUERY_LINK_ADDR 12'h152
`define QUERY_QTY_ADDR 12'h156
// ****************************************
// Field positions and reset values
// ****************************************
`define LINK_OFFSET_LSB 0
`define LINK_OFFSET_MSB 9
`define LINK_SEGMENT_LSB 10
`define LINK_SEGMENT_MSB 27
`define LINK_TYPE_LSB 28
`define LINK_TYPE_MSB 30
`define LINK_MORE_BIT 31
`define QTY_COUNT_MSB 3
`define QTY_DIE_BIT 4
`define QTY_LINK_BIT 5
`define LINK_RESET 32'hFFFF_FFFF
`define QUANTITY_RESET 8'hFF
`define IRQ_DONE_BIT 0
`define IRQ_LOCKERR_BIT 1
`define IRQ_BADCMD_BIT 2
// ****************************************
// Command codes
// ****************************************
`define CMD_READ_ARRAY 8'hFF
`define CMD_PROGRAM_A 8'h10
`define CMD_PROGRAM_B 8'h40
`define CMD_BUFFERED 8'hE8
`define CMD_ERASE 8'h20
`define CMD_FACTORY 8'h80
`define CMD_CONFIRM 8'hD0
`define CMD_SUSPEND 8'hB0
`define CMD_READ_STATUS 8'h70
`define CMD_CLEAR_STATUS 8'h50
`define CMD_READ_ID 8'h90
`define CMD_READ_QUERY 8'h98
`define CMD_LOCK_SETUP 8'h60
`define CMD_OTP_SETUP 8'hC0
`endif

// ===== fcsm_pkg.sv
package fcsm_pkg;
  // Command state machine states
  typedef enum logic [3:0] {
    ST_READY = 4'b0000,
    ST_PROG_SETUP = 4'b0001,
    ST_PROG_BUSY = 4'b0010,
    ST_PROG_SUSP = 4'b0011,
    ST_BUF_SETUP = 4'b0100,
    ST_BUF_BUSY = 4'b0101,
    ST_BUF_SUSP = 4'b0110,
    ST_ERASE_SETUP = 4'b0111,
    ST_ERASE_BUSY = 4'b1000,
    ST_ERASE_SUSP = 4'b1001,
    ST_FACT_SETUP = 4'b1010,
    ST_FACT_BUSY = 4'b1011,
    ST_LOCK_SETUP = 4'b1100,
    ST_OTP_SETUP = 4'b1101,
    ST_OTP_BUSY = 4'b1110
  } cmd_state_type;
  // Per-partition read state
  typedef enum logic [1:0] {
    RD_ARRAY = 2'b00,
    RD_IDENT = 2'b01,
    RD_QUERY = 2'b10,
    RD_STATUS = 2'b11
  } read_state_type;
  localparam int PARTITIONS = 4;
endpackage : fcsm_pkg

// ===== flash_command_state_machine.sv
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`include "fcsm_params.svh"
module flash_command_state_machine (
  // Clock, reset, enable
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic CLK_EN,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Interrupt
  output logic IRQ
);
  import fcsm_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  cmd_state_type state;
  cmd_state_type next_state;
  read_state_type read_state [PARTITIONS];
  logic [1:0] active_part;
  logic [31:0] link_field;
  logic [7:0] quantity;
  logic [2:0] irq_status;
  logic [2:0] irq_mask;
  logic lock_error;
  logic unlock_block;
  logic bad_cmd;
  logic wr_access;
  logic rd_access;
  logic cmd_write;
  logic done_write;
  logic [7:0] cmd_code;
  logic [1:0] cmd_part;
  logic op_done;
  logic [2:0] events;
  logic addr_ok;

  // ****************************************
  // APB decode
  // ****************************************
  // Single-cycle access: PREADY is always high, so no wait state is added
  assign PREADY = 1'b1;
  assign wr_access = PSEL & PENABLE & PWRITE & CLK_EN;
  assign rd_access = PSEL & ~PENABLE & ~PWRITE;
  assign cmd_write = wr_access & (PADDR == `OFS_COMMAND);
  assign done_write = wr_access & (PADDR == `OFS_DONE);
  assign cmd_code = PWDATA[7:0];
  assign cmd_part = PWDATA[9:8]; // Target partition of the command

  // Unmapped addresses answer with an error
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == `OFS_COMMAND) || (a == `OFS_STATE) || (a == `OFS_READ_STATE) ||
             (a == `OFS_LINK) || (a == `OFS_QUANTITY) || (a == `OFS_IRQ_STATUS) ||
             (a == `OFS_IRQ_MASK) || (a == `OFS_DONE);
  endfunction : mapped

  assign addr_ok = mapped(PADDR);
  assign PSLVERR = PSEL & PENABLE & ~addr_ok;

  // ****************************************
  // Command state machine
  // ****************************************
  fcsm_next_state u_table (
    .cur_state(state),
    .cmd(cmd_code),
    .next_state(next_state),
    .lock_error(lock_error),
    .unlock_block(unlock_block),
    .bad_cmd(bad_cmd)
  );

  // Busy states end when software reports the operation finished
  function automatic logic is_busy(input cmd_state_type s);
    is_busy = (s == ST_PROG_BUSY) || (s == ST_BUF_BUSY) || (s == ST_ERASE_BUSY) ||
              (s == ST_FACT_BUSY) || (s == ST_OTP_BUSY);
  endfunction : is_busy

  assign op_done = done_write & is_busy(state);

  // One machine state means only one partition can be programming or erasing
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      state <= ST_READY;
    end else if (CLK_EN) begin
      if (op_done) begin
        state <= ST_READY;
      end else if (cmd_write) begin
        state <= next_state;
      end
    end
  end

  // Partition that owns the running operation, captured at setup
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      active_part <= 2'b00;
    end else if (CLK_EN && cmd_write && state == ST_READY && next_state != ST_READY) begin
      active_part <= cmd_part;
    end
  end

  // ****************************************
  // Per-partition read states
  // ****************************************
  // Only the addressed partition moves; all others hold their read state
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      for (int i = 0; i < PARTITIONS; i++) begin
        read_state[i] <= RD_ARRAY;
      end
    end else if (CLK_EN && cmd_write) begin
      case (cmd_code)
        `CMD_READ_ARRAY: read_state[cmd_part] <= RD_ARRAY;
        `CMD_READ_ID: read_state[cmd_part] <= RD_IDENT;
        `CMD_READ_QUERY: read_state[cmd_part] <= RD_QUERY;
        `CMD_READ_STATUS: read_state[cmd_part] <= RD_STATUS;
        default: read_state[cmd_part] <= read_state[cmd_part];
      endcase
    end
  end

  // ****************************************
  // Query link field and quantity
  // ****************************************
  // Written by software; reset reads as all ones, quantity only in its six low bits, the single-die answer
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      link_field <= `LINK_RESET;
      quantity <= `QUANTITY_RESET;
    end else if (wr_access) begin
      if (PADDR == `OFS_LINK) begin
        link_field <= PWDATA;
      end
      if (PADDR == `OFS_QUANTITY) begin
        quantity <= PWDATA[7:0];
      end
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  assign events = {bad_cmd & cmd_write, lock_error & cmd_write, op_done};

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      irq_status <= 3'h0;
      irq_mask <= 3'h0;
    end else if (CLK_EN) begin
      if (wr_access && PADDR == `OFS_IRQ_MASK) begin
        irq_mask <= PWDATA[2:0];
      end
      if (wr_access && PADDR == `OFS_IRQ_STATUS) begin
        irq_status <= (irq_status & ~PWDATA[2:0]) | events;
      end else begin
        irq_status <= irq_status | events;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      IRQ <= 1'b0;
    end else if (CLK_EN) begin
      IRQ <= |(irq_status & irq_mask);
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  // Captured in the setup cycle so data is stable through the access phase
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      PRDATA <= 32'h0000_0000;
    end else if (CLK_EN && rd_access) begin
      case (PADDR)
        `OFS_STATE: PRDATA <= {22'h0, unlock_block, active_part, 3'h0, state};
        `OFS_READ_STATE: PRDATA <= {24'h0, read_state[3], read_state[2],
                                    read_state[1], read_state[0]};
        `OFS_LINK: PRDATA <= link_field;
        `OFS_QUANTITY: PRDATA <= {24'h0, 2'b00, quantity[5:0]};
        `OFS_IRQ_STATUS: PRDATA <= {29'h0, irq_status};
        `OFS_IRQ_MASK: PRDATA <= {29'h0, irq_mask};
        default: PRDATA <= 32'h0000_0000;
      endcase
    end
  end
endmodule : flash_command_state_machine

// ===== flash_command_state_machine_tb.sv
`timescale 1ns/10ps
`include "fcsm_params.svh"
module flash_command_state_machine_tb;
  import fcsm_pkg::*;
  logic clk, nrst, clk_en, psel, penable, pwrite, pready, pslverr, irq, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, seed;
  logic [7:0] codes [10] = '{8'hFF, 8'h70, 8'h10, 8'h40, 8'hE8, 8'h20, 8'h80, 8'h60,
                             8'h50, 8'h90};
  int err_total, tests_run, cycles;
  // ****************
  // Clock and parts
  // ****************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  flash_command_state_machine flash_command_state_machine_inst (.SYS_CLK(clk),
    .NRST(nrst), .CLK_EN(clk_en), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .IRQ(irq));
  fcsm_apb_host fcsm_apb_host_inst (.clk(clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  // State expected after one command from ready
  function automatic cmd_state_type fr(input logic [7:0] c);
    case (c)
      8'h10, 8'h40: return ST_PROG_SETUP;
      8'hE8: return ST_BUF_SETUP;
      8'h20: return ST_ERASE_SETUP;
      8'h80: return ST_FACT_SETUP;
      8'h60: return ST_LOCK_SETUP;
      default: return ST_READY;
    endcase
  endfunction : fr
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, x, s);
    end
  endtask : check
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    fcsm_apb_host_inst.xfer(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd(input logic [11:0] a);
    fcsm_apb_host_inst.xfer(1'b0, a, 32'h0000_0000, q, e);
  endtask : rd
  task automatic cmd(input logic [1:0] p, input logic [7:0] c);
    wr(`OFS_COMMAND, {22'h0, p, c});
  endtask : cmd
  task automatic st(input string n, input cmd_state_type x);
    rd(`OFS_STATE);
    check(n, 32'(q[3:0]), 32'(x));
  endtask : st
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report
  // Hang guard, well above the run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      final_report();
    end
  end
  // ****************
  // Scenarios
  // ****************
  initial begin
    nrst = 1'b0;
    clk_en = 1'b1;
    seed = 32'h0000_003C;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    rd(`OFS_LINK);
    check("link", q, `LINK_RESET);
    rd(`OFS_QUANTITY);
    check("qty", q, 32'h0000_003F);
    repeat (4) begin
      seed = xs(seed);
      wr(`OFS_LINK, seed);
      wr(`OFS_QUANTITY, seed);
      rd(`OFS_LINK);
      check("link", q, seed);
      rd(`OFS_QUANTITY);
      check("qty", q, seed & 32'h0000_003F);
    end
    // A write with the enable low is lost
    clk_en <= 1'b0;
    wr(`OFS_LINK, 32'h0000_0000);
    clk_en <= 1'b1;
    rd(`OFS_LINK);
    check("hold", q, seed);
    rd(12'h020);
    check("err", 32'(e), 32'h0000_0001);
    wr(`OFS_IRQ_MASK, 32'h0000_0007);
    foreach (codes[i]) begin
      cmd(seed[1:0], codes[i]);
      st("ready", fr(codes[i]));
      cmd(seed[1:0], 8'hFF);
      wr(`OFS_DONE, 32'h0000_0000);
      st("back", ST_READY);
      seed = xs(seed);
    end
    // Lock setup: confirm unlocks, other codes flag an error
    wr(`OFS_IRQ_STATUS, 32'h0000_0007);
    cmd(2'd0, 8'h60);
    cmd(2'd0, 8'hD0);
    rd(`OFS_IRQ_STATUS);
    check("unlock", q | 32'(irq), 32'h0000_0000);
    cmd(2'd0, 8'h60);
    cmd(2'd0, 8'h55);
    st("lockerr", ST_READY);
    rd(`OFS_IRQ_STATUS);
    check("lockerr", q, 32'h0000_0002);
    check("irq", 32'(irq), 32'h0000_0001);
    wr(`OFS_IRQ_MASK, 32'h0000_0000);
    rd(`OFS_IRQ_STATUS);
    check("mask", 32'(irq), 32'h0000_0000);
    wr(`OFS_IRQ_STATUS, 32'h0000_0002);
    wr(`OFS_IRQ_MASK, 32'h0000_0001);
    // Program with suspend and resume
    cmd(seed[1:0], 8'h40);
    cmd(seed[1:0], seed[15:8]);
    cmd(seed[1:0], 8'hB0);
    st("susp", ST_PROG_SUSP);
    cmd(seed[1:0], 8'hD0);
    st("resume", ST_PROG_BUSY);
    wr(`OFS_DONE, 32'h0000_0000);
    rd(`OFS_IRQ_STATUS);
    check("done", q | 32'(irq) << 4, 32'h0000_0011);
    // Erase in one partition locks the others out
    cmd(2'd2, 8'h20);
    cmd(2'd2, 8'hD0);
    cmd(2'd1, 8'h10);
    rd(`OFS_STATE);
    check("active", {q[8:7], q[3:0]}, {2'd2, ST_ERASE_BUSY});
    cmd(2'd0, 8'h70);
    cmd(2'd1, 8'h90);
    cmd(2'd2, 8'h98);
    cmd(2'd3, 8'hFF);
    st("busy", ST_ERASE_BUSY);
    wr(`OFS_DONE, 32'h0000_0000);
    cmd(2'd1, 8'h20);
    st("setup", ST_ERASE_SETUP);
    rd(`OFS_READ_STATE);
    check("rdst", q, 32'h0000_0027);
    final_report();
  end
endmodule : flash_command_state_machine_tb
